// file: design/decoder_timing_caption_params.svh
// offsets, field positions, reset values and timing counts
`ifndef DECODER_TIMING_CAPTION_PARAMS_SVH
`define DECODER_TIMING_CAPTION_PARAMS_SVH

`define REG_BURST_DELAY    8'h19
`define REG_CONV_IF        8'h1A
`define REG_VID_TIMING     8'h1B
`define REG_CAP_STATUS     8'h1C
`define REG_CAP_DATA       8'h1D

`define RST_BURST_DELAY    8'h5D
`define RST_CONV_IF        8'h82
`define RST_VID_TIMING     8'h00
`define RST_CAP_CTRL       3'h4

`define CONV_SYNC_LOW      5
`define CONV_GAIN_DIS      4
`define CONV_CLK_SLEEP     3
`define CONV_Y_SLEEP       2
`define CONV_C_SLEEP       1
`define CONV_WHITE_CRUSH   0

`define VT_LINE_FMT        7
`define VT_ACT_FMT         6
`define VT_CLK_GATE        5
`define VT_VBI_EN          4
`define VT_VBI_ORDER       3
`define VT_VALID_FMT       2
`define VT_TAP_HI          1
`define VT_TAP_LO          0

`define CS_PARITY          7
`define CS_IRQ_MASK        6
`define CS_EXT_EN          5
`define CS_CAP_EN          4
`define CS_OVERFLOW        3
`define CS_AVAIL           2
`define CS_TYPE            1
`define CS_POSITION        0

`define CLK_PERIOD_NS      5
`define WAKE_TIME_NS       1000000000
`define LINE_PULSE_TICKS   64

`endif

// file: design/decoder_timing_caption_pkg.sv
// types and helpers shared by the caption and timing logic
package decoder_timing_caption_pkg;

    typedef struct packed {
        logic       parity_fail;
        logic       extended;
        logic       high_byte;
        logic [7:0] value;
    } caption_entry_t;

    typedef enum logic [1:0] {
        LINE_IDLE  = 2'b01,
        LINE_PULSE = 2'b10
    } line_state_t;

    // one when the byte fails odd parity
    function automatic logic odd_parity_fail(input logic [7:0] b);
        return ~(^b);
    endfunction

endpackage

// file: design/caption_fifo_if.sv
// push and pop signals of the caption byte queue
`timescale 1ns/100ps
`default_nettype none
interface caption_fifo_if;
    import decoder_timing_caption_pkg::*;
    logic           push;
    caption_entry_t push_entry;
    logic           pop;
    logic           full;
    logic           empty;
    caption_entry_t head;

    modport queue (input push, push_entry, pop,
                   output full, empty, head);
    modport user  (output push, push_entry, pop,
                   input full, empty, head);
endinterface
`default_nettype wire

// file: design/caption_fifo.sv
// caption byte queue, show-ahead, flip-flop storage
`timescale 1ns/100ps
`default_nettype none
module caption_fifo #(
    parameter int DEPTH = 16
) (
    input  wire logic   clk_sys_i,
    input  wire logic   reset_i,
    input  wire logic   ce_i,
    caption_fifo_if.queue q
);
    import decoder_timing_caption_pkg::*;
    localparam int AW = $clog2(DEPTH);

    caption_entry_t   mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic             do_push;
    logic             do_pop;

    assign do_push = q.push && (!q.full || do_pop);
    assign do_pop  = q.pop && !q.empty;
    assign q.full  = (count_q == (AW+1)'(DEPTH));
    assign q.empty = (count_q == '0);
    assign q.head  = mem_q[rd_q];

    always_ff @(posedge clk_sys_i) begin
        if (ce_i && do_push) begin
            mem_q[wr_q] <= q.push_entry;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else if (ce_i) begin
            if (do_push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    a_count_bound: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        count_q <= (AW+1)'(DEPTH))
        else $error("caption queue count above depth");
endmodule // caption_fifo
`default_nettype wire

// file: design/decoder_timing_caption_regs.sv
// burst delay, converter, video timing and caption registers
`timescale 1ns/100ps
`default_nettype none
`include "decoder_timing_caption_params.svh"

module decoder_timing_caption_regs #(
    parameter int          FIFO_DEPTH  = 16,
    parameter int unsigned WAKE_CYCLES = `WAKE_TIME_NS / `CLK_PERIOD_NS
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_rvalid_o,
    input  wire logic        luma_comb_enable_i,
    input  wire logic        single_rate_clock_i,
    input  wire logic        double_rate_clock_i,
    input  wire logic        wide_mode_i,
    input  wire logic        single_rate_tick_i,
    input  wire logic        line_start_i,
    input  wire logic        horizontal_active_i,
    input  wire logic        vertical_active_i,
    input  wire logic        internal_valid_i,
    input  wire logic [15:0] video_data_i,
    input  wire logic [7:0]  blank_pixel_n_i,
    input  wire logic [7:0]  blank_pixel_n1_i,
    input  wire logic        caption_byte_valid_i,
    input  wire logic [7:0]  caption_byte_i,
    input  wire logic        caption_byte_ext_i,
    input  wire logic        caption_byte_high_i,
    output logic      [7:0]  burst_gate_delay_value_o,
    output logic             reference_drive_out_o,
    output logic             sync_threshold_low_o,
    output logic             system_clock_run_o,
    output logic             luma_conv_sleep_o,
    output logic             chroma_conv_sleep_o,
    output logic             white_crush_o,
    output logic             line_sync_out_o,
    output logic             active_pin_o,
    output logic             pixel_valid_out_o,
    output logic             qualified_clock_o,
    output logic      [15:0] pixel_data_bus_o,
    output logic      [2:0]  filter_taps_o,
    output logic             interpolate_o,
    output logic             caption_power_down_o,
    output logic             caption_irq_pin_o
);
    import decoder_timing_caption_pkg::*;

    logic [7:0]     burst_q;
    logic [7:0]     conv_q;
    logic [7:0]     vt_q;
    logic [2:0]     cap_ctrl_q;
    logic           overflow_q;
    logic [27:0]    wake_cnt_q;
    line_state_t    line_state_q;
    logic [6:0]     pulse_ticks_q;
    logic           wr_burst;
    logic           wr_conv;
    logic           wr_vt;
    logic           wr_cs;
    logic           rd_data;
    logic           active_c;
    logic           rate_clk_c;
    logic           in_blank_c;
    logic           cap_accept_c;
    logic [7:0]     status_c;
    logic [7:0]     rdata_c;
    caption_fifo_if cq ();

    assign wr_burst = reg_wr_i && (reg_addr_i == `REG_BURST_DELAY);
    assign wr_conv  = reg_wr_i && (reg_addr_i == `REG_CONV_IF);
    assign wr_vt    = reg_wr_i && (reg_addr_i == `REG_VID_TIMING);
    assign wr_cs    = reg_wr_i && (reg_addr_i == `REG_CAP_STATUS);
    assign rd_data  = reg_rd_i && (reg_addr_i == `REG_CAP_DATA);
    // control registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            burst_q    <= `RST_BURST_DELAY;
            conv_q     <= `RST_CONV_IF;
            vt_q       <= `RST_VID_TIMING;
            cap_ctrl_q <= `RST_CAP_CTRL;
        end else if (ce_i) begin
            if (wr_burst) begin
                burst_q <= reg_wdata_i;
            end
            if (wr_conv) begin
                conv_q <= reg_wdata_i;
            end
            if (wr_vt) begin
                vt_q <= reg_wdata_i;
            end
            if (wr_cs) begin
                cap_ctrl_q <= reg_wdata_i[`CS_IRQ_MASK:`CS_CAP_EN];
            end
        end
    end
    // caption capture into the queue
    assign cap_accept_c = caption_byte_ext_i ? cap_ctrl_q[1] : cap_ctrl_q[0];
    assign cq.push = caption_byte_valid_i && cap_accept_c;
    assign cq.push_entry = '{parity_fail: odd_parity_fail(caption_byte_i),
                             extended:    caption_byte_ext_i,
                             high_byte:   caption_byte_high_i,
                             value:       caption_byte_i};
    assign cq.pop = rd_data;

    caption_fifo #(
        .DEPTH (FIFO_DEPTH)
    ) u_queue (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .q         (cq.queue)
    );
    // sticky overflow; a data read frees a slot, so no loss then
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            overflow_q <= 1'b0;
        end else if (ce_i) begin
            if (cq.push && cq.full && !rd_data) begin
                overflow_q <= 1'b1;
            end else if (rd_data) begin
                overflow_q <= 1'b0;
            end
        end
    end

    always_comb begin
        status_c = {cq.head.parity_fail && !cq.empty, cap_ctrl_q,
                    overflow_q, !cq.empty,
                    cq.head.extended, cq.head.high_byte};
        unique case (reg_addr_i)
            `REG_BURST_DELAY: rdata_c = burst_q;
            `REG_CONV_IF:     rdata_c = conv_q;
            `REG_VID_TIMING:  rdata_c = vt_q;
            `REG_CAP_STATUS:  rdata_c = status_c;
            `REG_CAP_DATA:    rdata_c = cq.head.value;
            default:          rdata_c = 8'h00;
        endcase
    end
    // registered read answer
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_c;
            end
        end
    end
    // converter and power outputs
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            burst_gate_delay_value_o <= `RST_BURST_DELAY;
            reference_drive_out_o    <= 1'b1;
            sync_threshold_low_o     <= 1'b0;
            luma_conv_sleep_o        <= 1'b0;
            chroma_conv_sleep_o      <= 1'b1;
            white_crush_o            <= 1'b0;
            caption_power_down_o     <= 1'b1;
            caption_irq_pin_o        <= 1'b0;
        end else if (ce_i) begin
            burst_gate_delay_value_o <= burst_q;
            reference_drive_out_o    <= !conv_q[`CONV_GAIN_DIS];
            sync_threshold_low_o     <= conv_q[`CONV_SYNC_LOW];
            luma_conv_sleep_o        <= conv_q[`CONV_Y_SLEEP];
            chroma_conv_sleep_o      <= conv_q[`CONV_C_SLEEP];
            white_crush_o            <= conv_q[`CONV_WHITE_CRUSH];
            caption_power_down_o     <= (cap_ctrl_q[1:0] == 2'b00);
            caption_irq_pin_o        <= cap_ctrl_q[2] && !cq.empty;
        end
    end
    // system clock sleep and wake-up delay
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wake_cnt_q         <= '0;
            system_clock_run_o <= 1'b1;
        end else if (ce_i) begin
            if (conv_q[`CONV_CLK_SLEEP]) begin
                wake_cnt_q         <= '0;
                system_clock_run_o <= 1'b0;
            end else if (!system_clock_run_o) begin
                if (wake_cnt_q == 28'(WAKE_CYCLES - 1)) begin
                    system_clock_run_o <= 1'b1;
                end else begin
                    wake_cnt_q <= wake_cnt_q + 28'h0000001;
                end
            end
        end
    end
    // line sync pulse
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            line_state_q    <= LINE_IDLE;
            pulse_ticks_q   <= '0;
            line_sync_out_o <= 1'b0;
        end else if (ce_i) begin
            unique case (line_state_q)
                LINE_IDLE: begin
                    if (line_start_i) begin
                        line_state_q    <= LINE_PULSE;
                        pulse_ticks_q   <= '0;
                        line_sync_out_o <= 1'b1;
                    end
                end
                LINE_PULSE: begin
                    if (single_rate_tick_i) begin
                        if (vt_q[`VT_LINE_FMT] ||
                            pulse_ticks_q == 7'(`LINE_PULSE_TICKS - 1)) begin
                            line_state_q    <= LINE_IDLE;
                            line_sync_out_o <= 1'b0;
                        end else begin
                            pulse_ticks_q <= pulse_ticks_q + 7'h01;
                        end
                    end
                end
            endcase
        end
    end
    // active, valid, qualified clock and data bus
    assign active_c   = vt_q[`VT_ACT_FMT] ? horizontal_active_i
                      : horizontal_active_i && vertical_active_i;
    assign rate_clk_c = wide_mode_i ? single_rate_clock_i
                      : double_rate_clock_i;
    assign in_blank_c = !vertical_active_i && vt_q[`VT_VBI_EN];

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            active_pin_o      <= 1'b0;
            pixel_valid_out_o <= 1'b0;
            qualified_clock_o <= 1'b0;
            pixel_data_bus_o  <= 16'h0000;
        end else if (ce_i) begin
            active_pin_o <= active_c;
            if (!vt_q[`VT_VALID_FMT]) begin
                pixel_valid_out_o <= internal_valid_i && active_c;
                qualified_clock_o <= !rate_clk_c;
            end else begin
                pixel_valid_out_o <= internal_valid_i;
                qualified_clock_o <= rate_clk_c && internal_valid_i &&
                    (vt_q[`VT_CLK_GATE] || active_c);
            end
            if (in_blank_c) begin
                pixel_data_bus_o <= vt_q[`VT_VBI_ORDER]
                    ? {blank_pixel_n1_i, blank_pixel_n_i}
                    : {blank_pixel_n_i, blank_pixel_n1_i};
            end else begin
                pixel_data_bus_o <= video_data_i;
            end
        end
    end
    // vertical filter mode
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            filter_taps_o <= 3'h2;
            interpolate_o <= 1'b0;
        end else if (ce_i) begin
            if (luma_comb_enable_i) begin
                filter_taps_o <= 3'h2 + {1'b0, vt_q[1:0]};
                interpolate_o <= 1'b0;
            end else begin
                filter_taps_o <= (vt_q[1:0] == 2'b00) ? 3'h0
                               : 3'h1 + {1'b0, vt_q[1:0]};
                interpolate_o <= 1'b1;
            end
        end
    end

    a_burst_reset: assert property (@(posedge clk_sys_i)
        $fell(reset_i) |-> burst_q == `RST_BURST_DELAY)
        else $error("burst delay reset value wrong");
    a_conv_reset: assert property (@(posedge clk_sys_i)
        $fell(reset_i) |-> conv_q == `RST_CONV_IF && chroma_conv_sleep_o)
        else $error("converter reset value wrong");
    a_ref_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_conv && ce_i ##1 ce_i |=>
        reference_drive_out_o == !$past(reg_wdata_i[`CONV_GAIN_DIS], 2))
        else $error("reference drive does not follow gain bit");
    a_line_end: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $fell(line_sync_out_o) |->
        $past(vt_q[`VT_LINE_FMT]) ||
        $past(pulse_ticks_q) == 7'(`LINE_PULSE_TICKS - 1))
        else $error("line pulse ended early");
    a_active_fmt: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && horizontal_active_i && !vertical_active_i
        && !vt_q[`VT_ACT_FMT] |=> !active_pin_o)
        else $error("composite active ignored vertical");
    a_qualified_clock_gate: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && vt_q[`VT_VALID_FMT] && !vt_q[`VT_CLK_GATE] && !active_c
        |=> !qualified_clock_o)
        else $error("qualified clock not gated by active");
    a_byte_order: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && in_blank_c && !vt_q[`VT_VBI_ORDER] |=>
        pixel_data_bus_o[15:8] == $past(blank_pixel_n_i))
        else $error("blanking byte order wrong");
    a_irq_mask: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && !cap_ctrl_q[2] |=> !caption_irq_pin_o)
        else $error("masked caption interrupt asserted");
    a_ovf_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && cq.push && cq.full && !rd_data |=> overflow_q)
        else $error("lost caption byte not flagged");
    a_pop_empty: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ce_i && rd_data && $past(cq.empty) && cq.empty && !cq.push
        |=> cq.empty)
        else $error("pop on empty queue changed state");
endmodule // decoder_timing_caption_regs
`default_nettype wire

// file: sim/video_source_model.sv
// rate clocks and single-rate tick from the video front end
`timescale 1ns/100ps
`default_nettype none
module video_source_model (
    input  wire logic clk_sys_i,
    output logic      single_rate_clock_o,
    output logic      double_rate_clock_o,
    output logic      single_rate_tick_o
);
    logic [1:0] phase_q = 2'h0;
    // moves off the falling edge, settled at the sampling edge
    always @(negedge clk_sys_i) phase_q <= phase_q + 2'h1;
    assign double_rate_clock_o = phase_q[0];
    assign single_rate_clock_o = phase_q[1];
    assign single_rate_tick_o  = (phase_q == 2'h3);
endmodule // video_source_model
`default_nettype wire

// file: sim/test_decoder_timing_caption_regs.sv
// self-checking bench for the timing and caption registers
`timescale 1ns/100ps
`default_nettype none
`include "decoder_timing_caption_params.svh"
module test_decoder_timing_caption_regs;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, comb = 0, wide = 0, en = 1;
    logic        ha = 0, va = 0, iv = 0, ls = 0, cv = 0, ce = 0, ch = 0;
    logic [7:0]  ad = 0, wd = 0, pn = 0, pn1 = 0, cb = 0, rdat, bgd;
    logic [15:0] vd = 0, bus;
    logic [2:0]  taps;
    logic        rv, refd, syl, run, ysl, csl, wcr, lsy, act, pv, qc;
    logic        itp, cpd, irq, s_q, d_q;
    wire         sr, dr, tk;
    int          n_fail = 0, tests_run = 0, cycles = 0;
    logic [15:0] expq [$];

    video_source_model i_src (.clk_sys_i(clk), .single_rate_clock_o(sr),
        .double_rate_clock_o(dr), .single_rate_tick_o(tk));
    decoder_timing_caption_regs #(.FIFO_DEPTH(4), .WAKE_CYCLES(20)) i_dut (
        .clk_sys_i(clk), .reset_i(rst), .ce_i(en), .reg_addr_i(ad),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .reg_rvalid_o(rv), .luma_comb_enable_i(comb),
        .single_rate_clock_i(sr), .double_rate_clock_i(dr),
        .wide_mode_i(wide), .single_rate_tick_i(tk), .line_start_i(ls),
        .horizontal_active_i(ha), .vertical_active_i(va),
        .internal_valid_i(iv), .video_data_i(vd), .blank_pixel_n_i(pn),
        .blank_pixel_n1_i(pn1), .caption_byte_valid_i(cv),
        .caption_byte_i(cb), .caption_byte_ext_i(ce),
        .caption_byte_high_i(ch), .burst_gate_delay_value_o(bgd),
        .reference_drive_out_o(refd), .sync_threshold_low_o(syl),
        .system_clock_run_o(run), .luma_conv_sleep_o(ysl),
        .chroma_conv_sleep_o(csl), .white_crush_o(wcr),
        .line_sync_out_o(lsy), .active_pin_o(act), .pixel_valid_out_o(pv),
        .qualified_clock_o(qc), .pixel_data_bus_o(bus),
        .filter_taps_o(taps), .interpolate_o(itp),
        .caption_power_down_o(cpd), .caption_irq_pin_o(irq));

    initial forever #2.5 clk = ~clk;

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        ad = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
        cyc(2);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
                          input logic [7:0] m);
        @(negedge clk);
        ad = a;
        rd = 1;
        expq.push_back({m, e});
        @(negedge clk);
        rd = 0;
    endtask

    task automatic offer(input logic [7:0] b, input logic e, input logic h);
        @(negedge clk);
        {cb, ce, ch} = {b, e, h};
        cv = 1;
        @(negedge clk);
        cv = 0;
    endtask

    always @(posedge clk) begin
        s_q <= sr;
        d_q <= dr;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    always @(negedge clk) begin
        logic [15:0] e;
        if (rv === 1'b1 && expq.size() == 0) begin
            check("read answer", 16'h0000, 16'h0001);
        end else if (rv === 1'b1) begin
            e = expq.pop_front();
            if (e[15:8] != 8'h00) begin
                check("read data", {8'h00, e[7:0] & e[15:8]},
                      {8'h00, rdat & e[15:8]});
            end
        end
    end

    initial begin
        int         i;
        int         n;
        logic [7:0] v;
        logic [7:0] bq [5];
        logic       a;
        void'($urandom(87));
        repeat (8) @(negedge clk);
        rst = 0;
        check("conv outs", 6'h34, {refd, run, ysl, csl, syl, wcr});
        check("burst out", 8'h5D, bgd);
        check("taps", 4'h4, {taps, itp});
        check("caption idle", 2'b10, {cpd, irq});
        rd_reg(`REG_BURST_DELAY, `RST_BURST_DELAY, 8'hFF);
        rd_reg(`REG_CONV_IF, `RST_CONV_IF, 8'hFF);
        rd_reg(`REG_VID_TIMING, `RST_VID_TIMING, 8'hFF);
        rd_reg(`REG_CAP_STATUS, 8'h40, 8'h7C);
        rd_reg(8'h30, 8'h00, 8'hFF);
        v = 8'($urandom);
        wr_reg(`REG_BURST_DELAY, v);
        rd_reg(`REG_BURST_DELAY, v, 8'hFF);
        check("burst out", v, bgd);
        cyc(1);
        en = 0;
        wr_reg(`REG_BURST_DELAY, ~v);
        en = 1;
        rd_reg(`REG_BURST_DELAY, v, 8'hFF);
        check("burst frozen", v, bgd);
        for (i = 1; i < 6; i++) begin
            if (i == 3) continue;
            v = 8'h80 | (8'h01 << i);
            wr_reg(`REG_CONV_IF, v);
            rd_reg(`REG_CONV_IF, v, 8'hFF);
            check("conv outs", {~v[4], v[2], v[1], v[5], 2'b10},
                  {refd, ysl, csl, syl, run, wcr});
        end
        wr_reg(`REG_CONV_IF, 8'h88);
        check("clock run", 1'b0, run);
        wr_reg(`REG_CONV_IF, 8'h82);
        cyc(8);
        check("clock run", 1'b0, run);
        cyc(20);
        check("clock run", 1'b1, run);
        for (i = 0; i < 8; i++) begin
            comb = i[2];
            wr_reg(`REG_VID_TIMING, {6'h00, i[1:0]});
            if (comb) check("taps", {3'(i[1:0]) + 3'h2, 1'b0},
                            {taps, itp});
            else check("taps", {(i[1:0] == 0) ? 3'h0 : 3'(i[1:0]) + 3'h1,
                       1'b1}, {taps, itp});
        end
        for (i = 0; i < 2; i++) begin
            wr_reg(`REG_VID_TIMING, {i[0], 7'h00});
            @(negedge clk);
            ls = 1;
            @(negedge clk);
            ls = 0;
            n = 0;
            repeat (300) begin
                @(posedge clk);
                if (lsy === 1'b1 && tk === 1'b1) n++;
            end
            check("line ticks", (i == 1) ? 16'd1 : 16'd64, 16'(n));
        end
        for (i = 0; i < 32; i++) begin
            {ha, va, iv, wide} = 4'($urandom);
            v = 8'($urandom) & 8'h64;
            wr_reg(`REG_VID_TIMING, v);
            a = v[6] ? ha : ha & va;
            check("active pin", a, act);
            if (!v[2]) begin
                check("valid", iv & a, pv);
                check("free clock", {15'h0000, ~(wide ? s_q : d_q)},
                      qc);
            end else if (!iv || (!v[5] && !a)) begin
                check("gated clock", 1'b0, qc);
            end
        end
        va = 0;
        for (i = 0; i < 4; i++) begin
            {vd, pn, pn1} = 32'($urandom);
            wr_reg(`REG_VID_TIMING, {3'h0, i[1:0], 3'h0});
            check("pixel bus", !i[1] ? vd : i[0] ? {pn1, pn} : {pn, pn1},
                  bus);
        end
        wr_reg(`REG_CAP_STATUS, 8'h50);
        offer(8'h11, 1'b1, 1'b0);
        rd_reg(`REG_CAP_STATUS, 8'h50, 8'h7C);
        for (i = 0; i < 5; i++) begin
            bq[i] = 8'($urandom);
            offer(bq[i], 1'b0, i[0]);
        end
        wr_reg(`REG_CAP_DATA, 8'hA5);
        check("irq pin", 1'b1, irq);
        rd_reg(`REG_CAP_STATUS, {~^bq[0], 7'h5C}, 8'hFF);
        for (i = 0; i < 4; i++) begin
            rd_reg(`REG_CAP_DATA, bq[i], 8'hFF);
            if (i < 3) rd_reg(`REG_CAP_STATUS, {~^bq[i + 1], 6'h2A, ~i[0]},
                              8'hFF);
            else rd_reg(`REG_CAP_STATUS, 8'h50, 8'h7C);
        end
        check("irq pin", 1'b0, irq);
        wr_reg(`REG_CAP_STATUS, 8'h20);
        offer(8'h80, 1'b1, 1'b1);
        cyc(1);
        check("caption state", 2'b00, {cpd, irq});
        rd_reg(`REG_CAP_STATUS, 8'h27, 8'hFF);
        rd_reg(`REG_CAP_DATA, 8'h80, 8'hFF);
        wr_reg(`REG_CAP_STATUS, 8'h40);
        check("caption off", 1'b1, cpd);
        rd_reg(`REG_CAP_DATA, 8'h00, 8'h00);
        rd_reg(`REG_CAP_STATUS, 8'h40, 8'h7C);
        cyc(4);
        check("reads left", 16'h0000, 16'(expq.size()));
        test_done();
    end
endmodule // test_decoder_timing_caption_regs
`default_nettype wire
